// file: cpr_defs.svh
// Offsets, field positions, reset values and counts of the clock/power/reset controller.
// Included by the package and the top module; definitions only.
`ifndef CPR_DEFS_SVH
`define CPR_DEFS_SVH

// Register byte addresses
`define CPR_ADR_STOP 32'h4000_0020
`define CPR_ADR_CLOCK_SOURCE_CONTROL 32'h4000_0024
`define CPR_ADR_CLKDIV 32'h4000_0028
`define CPR_ADR_PWR 32'h4000_0030
`define CPR_ADR_SRST 32'h4000_0038
`define CPR_ADR_IRQ_STS 32'h4000_0040
`define CPR_ADR_IRQ_CLR 32'h4000_0044
`define CPR_ADR_IRQ_EN 32'h4000_0048

// Reset values
`define CPR_RST_CLOCK_SOURCE_CONTROL 32'h0000_0004
`define CPR_RST_CLKDIV 32'h0000_0300
`define CPR_RST_PWR 32'h0000_1000
`define CPR_RST_SRST 32'h0000_0000

// Writable bit masks; all other bits are reserved
`define CPR_MSK_CLOCK_SOURCE_CONTROL 32'h0000_01b7
`define CPR_MSK_CLKDIV 32'h0000_0ff7
`define CPR_MSK_PWR 32'h0000_1eff
`define CPR_MSK_SRST 32'h0000_00ff

// Field positions
`define CPR_SRC_OSC_KEEP 8
`define CPR_SRC_SEC_OFF 7
`define CPR_SRC_MAIN_OFF 5
`define CPR_SRC_ROOT_SEL 4
`define CPR_SRC_EXT_DIV 0
`define CPR_DIV_VIDEO 4
`define CPR_DIV_CAMERA 8
`define CPR_DIV_SYS 1
`define CPR_DIV_PER 0
`define CPR_PWR_HS_EN 12
`define CPR_PWR_MODEM_MASK 11
`define CPR_PWR_BF 9

// Codes
`define CPR_MAGIC 8'ha3
`define CPR_BF_SLEEP 2'h0
`define CPR_BF_FIQ 2'h1
`define CPR_EXT_RSVD 3'h7

// Synchroniser lanes
`define CPR_SYN_STBY 0
`define CPR_SYN_WAKE 1
`define CPR_SYN_MODEM 2
`define CPR_SYN_BF 3
`define CPR_SYN_EXT 4

// Interrupt status bits
`define CPR_IRQ_ENTER 0
`define CPR_IRQ_WAKE 1
`define CPR_IRQ_BF 2

// Soft reset pulse: time in ns and cycles at 50 MHz
`define CPR_CLK_NS 20
`define CPR_SRST_NS 320
`define CPR_SRST_CYC ((`CPR_SRST_NS + `CPR_CLK_NS - 1) / `CPR_CLK_NS)

`endif

// file: cpr_pkg.sv
// Types shared by the clock/power/reset controller modules.
// Assumes cpr_defs.svh is on the include path.
`include "cpr_defs.svh"

package cpr_pkg;

	// Power manager states
	typedef enum logic [1:0] {
		CPR_PM_RUN = 2'b00,
		CPR_PM_WAIT = 2'b01,
		CPR_PM_STOP = 2'b10,
		CPR_PM_SLEEP = 2'b11
	} cpr_pm_state_t;

	// Wishbone classic request from the master
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [31:0] adr;
		logic [31:0] dat;
	} cpr_wb_req_t;

	// Tick divider state
	typedef struct packed {
		logic [3:0] cnt;
		logic tick;
	} cpr_div_st_t;

	// Controller state
	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic stop_req;
		logic [31:0] clock_source_control;
		logic [31:0] clkdiv;
		logic [31:0] pwr;
		logic [31:0] srst;
		logic [2:0] sts;
		logic [2:0] ien;
		logic irq;
		logic [4:0] s1;
		logic [4:0] s2;
		logic [4:0] s3;
		cpr_pm_state_t pm;
		logic tgt_sleep;
		logic [4:0] srst_cnt;
		logic srst_out;
		logic fast_interrupt;
		logic osc_run;
		logic main_on;
		logic sec_on;
		logic root_sel;
		logic in_stop;
		logic in_sleep;
	} cpr_st_t;

endpackage

// file: cpr_tick_div.sv
// Clock-enable tick divider: one tick every (period_i + 1) advance strobes.
// Assumes adv_i and period_i come from logic on clk_i.
`timescale 1ns/1ns

module cpr_tick_div
	import cpr_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic adv_i,
	input wire logic [3:0] period_i,
	// Tick out
	output logic tick_o
);

	cpr_div_st_t q; // Registered state
	cpr_div_st_t d; // Next state

	// Count strobes; a shrinking period takes effect at once
	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (adv_i) begin
			if (q.cnt >= period_i) begin
				d.cnt = 4'h0;
				d.tick = 1'b1;
			end else begin
				d.cnt = q.cnt + 4'h1;
			end
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tick_o = q.tick;

endmodule

// file: cpr_top.sv
// Clock source, clock ratio, power mode and software reset controller.
// Assumes a Wishbone classic master on clk_i (core clock) and asynchronous
// pins for standby, wakeup, modem wakeup, battery fault and external clock.
`timescale 1ns/1ns
`include "cpr_defs.svh"

module cpr_top
	import cpr_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone classic slave
	input cpr_wb_req_t wb_req_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Pins from core and system
	input wire logic core_standby_signal_i,
	input wire logic wakeup_i,
	input wire logic modem_wakeup_i,
	input wire logic battery_fault_i,
	input wire logic ext_clk_i,
	// Clock controls
	output logic osc_run_o,
	output logic main_pll_on_o,
	output logic secondary_pll_on_o,
	output logic root_source_select_o,
	output logic ext_clk_en_o,
	output logic sys_bus_clk_en_o,
	output logic periph_bus_clk_en_o,
	output logic [3:0] camera_clock_divider_o,
	output logic [3:0] video_clock_divider_o,
	// Power and reset
	output logic stop_mode_o,
	output logic sleep_mode_o,
	output logic soft_reset_o,
	output logic fast_interrupt_o,
	output logic irq_o
);

	////////////////////////////////////////////////////////////////////////////
	// State and decode

	cpr_st_t q; // Registered state
	cpr_st_t d; // Next state
	logic acc; // Bus access taken this cycle
	logic wr; // Write taken this cycle
	logic [31:0] wmask; // Byte lane mask
	logic magic; // Low byte carries the magic code
	logic pwr_magic_wr; // Sleep code write
	logic srst_magic_wr; // Soft reset code write
	logic stop_wr; // Stop request written to one
	logic wake; // Valid wakeup seen
	logic bf_rise; // Battery fault edge
	logic ext_rise; // External clock edge
	logic [3:0] ext_period; // External tick period minus one
	logic sys_tick; // System bus enable tick
	logic [2:0] ev; // Interrupt events

	// Request decode; ack toggles so each access takes two edges
	always_comb begin
		acc = wb_req_i.cyc & wb_req_i.stb & ~q.ack;
		wr = acc & wb_req_i.we;
		wmask = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
			{8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
		magic = wb_req_i.sel[0] & (wb_req_i.dat[7:0] == `CPR_MAGIC);
		pwr_magic_wr = wr & magic & (wb_req_i.adr == `CPR_ADR_PWR);
		srst_magic_wr = wr & magic & (wb_req_i.adr == `CPR_ADR_SRST);
		stop_wr = wr & wb_req_i.sel[0] & wb_req_i.dat[0] & (wb_req_i.adr == `CPR_ADR_STOP);
		// Masked modem events never wake the chip
		wake = q.s2[`CPR_SYN_WAKE]
			| (q.s2[`CPR_SYN_MODEM] & ~q.pwr[`CPR_PWR_MODEM_MASK]);
		bf_rise = q.s2[`CPR_SYN_BF] & ~q.s3[`CPR_SYN_BF];
		ext_rise = q.s2[`CPR_SYN_EXT] & ~q.s3[`CPR_SYN_EXT];
	end

	////////////////////////////////////////////////////////////////////////////
	// Clock enable dividers

	// Code 0 passes every edge; 1..6 give one tick per 2N edges
	always_comb begin
		case (q.clock_source_control[`CPR_SRC_EXT_DIV +: 3])
			3'h0: ext_period = 4'h0;
			`CPR_EXT_RSVD: ext_period = 4'h0; // Test code runs undivided
			default: ext_period = {q.clock_source_control[`CPR_SRC_EXT_DIV +: 3], 1'b0} - 4'h1;
		endcase
	end

	// External clock edges divided
	cpr_tick_div u_ext_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.adv_i(ext_rise),
		.period_i(ext_period),
		.tick_o(ext_clk_en_o)
	);

	// System bus: one tick per 1..4 core cycles
	cpr_tick_div u_sys_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.adv_i(1'b1),
		.period_i({2'b00, q.clkdiv[`CPR_DIV_SYS +: 2]}),
		.tick_o(sys_tick)
	);

	// Peripheral bus: every or every second system tick
	cpr_tick_div u_per_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.adv_i(sys_tick),
		.period_i({3'b000, q.clkdiv[`CPR_DIV_PER]}),
		.tick_o(periph_bus_clk_en_o)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next state

	// Registers, power manager, soft reset and interrupts in one pass
	always_comb begin
		d = q;
		ev = 3'b000;
		// Two-flop synchronisers; only s2 and later are read by logic
		d.s1 = {ext_clk_i, battery_fault_i, modem_wakeup_i, wakeup_i, core_standby_signal_i};
		d.s2 = q.s1;
		d.s3 = q.s2;
		// Bus answer one cycle after the request
		d.ack = acc;
		d.rdat = 32'h0000_0000;
		if (acc & ~wb_req_i.we) begin
			// Unmapped and write-only addresses read zero
			case (wb_req_i.adr)
				`CPR_ADR_STOP: d.rdat = {31'h0000_0000, q.stop_req};
				`CPR_ADR_CLOCK_SOURCE_CONTROL: d.rdat = q.clock_source_control;
				`CPR_ADR_CLKDIV: d.rdat = q.clkdiv;
				`CPR_ADR_PWR: d.rdat = q.pwr;
				`CPR_ADR_SRST: d.rdat = q.srst;
				`CPR_ADR_IRQ_STS: d.rdat = {29'h0000_0000, q.sts};
				`CPR_ADR_IRQ_EN: d.rdat = {29'h0000_0000, q.ien};
				default: d.rdat = 32'h0000_0000;
			endcase
		end
		if (wr) begin
			// Only writable bits change; reserved bits stay zero
			case (wb_req_i.adr)
				`CPR_ADR_STOP: begin
					if (wb_req_i.sel[0])
						d.stop_req = wb_req_i.dat[0];
				end
				`CPR_ADR_CLOCK_SOURCE_CONTROL: d.clock_source_control = (q.clock_source_control & ~(wmask & `CPR_MSK_CLOCK_SOURCE_CONTROL))
					| (wb_req_i.dat & wmask & `CPR_MSK_CLOCK_SOURCE_CONTROL);
				`CPR_ADR_CLKDIV: d.clkdiv = (q.clkdiv & ~(wmask & `CPR_MSK_CLKDIV))
					| (wb_req_i.dat & wmask & `CPR_MSK_CLKDIV);
				`CPR_ADR_PWR: d.pwr = (q.pwr & ~(wmask & `CPR_MSK_PWR))
					| (wb_req_i.dat & wmask & `CPR_MSK_PWR);
				`CPR_ADR_SRST: d.srst = (q.srst & ~(wmask & `CPR_MSK_SRST))
					| (wb_req_i.dat & wmask & `CPR_MSK_SRST);
				`CPR_ADR_IRQ_EN: begin
					if (wb_req_i.sel[0])
						d.ien = wb_req_i.dat[2:0];
				end
				default: d.ien = q.ien; // Unmapped writes ignored
			endcase
		end
		// Power manager
		case (q.pm)
			CPR_PM_RUN: begin
				if (bf_rise && q.pwr[`CPR_PWR_BF +: 2] == `CPR_BF_SLEEP) begin
					d.pm = CPR_PM_SLEEP;
					ev[`CPR_IRQ_ENTER] = 1'b1;
				end else if (pwr_magic_wr | stop_wr) begin
					d.tgt_sleep = pwr_magic_wr;
					// Handshake mode holds entry until the core idles
					if (q.pwr[`CPR_PWR_HS_EN]) begin
						d.pm = CPR_PM_WAIT;
					end else begin
						d.pm = pwr_magic_wr ? CPR_PM_SLEEP : CPR_PM_STOP;
						ev[`CPR_IRQ_ENTER] = 1'b1;
					end
				end
			end
			CPR_PM_WAIT: begin
				if (bf_rise && q.pwr[`CPR_PWR_BF +: 2] == `CPR_BF_SLEEP) begin
					d.pm = CPR_PM_SLEEP;
					ev[`CPR_IRQ_ENTER] = 1'b1;
				end else if (q.s2[`CPR_SYN_STBY]) begin
					d.pm = q.tgt_sleep ? CPR_PM_SLEEP : CPR_PM_STOP;
					ev[`CPR_IRQ_ENTER] = 1'b1;
				end
			end
			CPR_PM_STOP, CPR_PM_SLEEP: begin
				// Wake needs an unmasked source; the wakeup pin is never masked
				if (wake) begin
					d.pm = CPR_PM_RUN;
					ev[`CPR_IRQ_WAKE] = 1'b1;
				end
			end
			default: d.pm = CPR_PM_RUN;
		endcase
		// Ignore policy raises no event at all
		if (bf_rise && q.pwr[`CPR_PWR_BF +: 2] != 2'h2 && q.pwr[`CPR_PWR_BF +: 2] != 2'h3)
			ev[`CPR_IRQ_BF] = 1'b1;
		d.fast_interrupt = q.s2[`CPR_SYN_BF] & (q.pwr[`CPR_PWR_BF +: 2] == `CPR_BF_FIQ);
		// Soft reset pulse of fixed length
		if (srst_magic_wr)
			d.srst_cnt = 5'(`CPR_SRST_CYC);
		else if (q.srst_cnt != 5'h00)
			d.srst_cnt = q.srst_cnt - 5'h01;
		d.srst_out = (d.srst_cnt != 5'h00);
		// Sticky status: a new event beats a clear in the same cycle
		if (wr && wb_req_i.adr == `CPR_ADR_IRQ_CLR && wb_req_i.sel[0])
			d.sts = q.sts & ~wb_req_i.dat[2:0];
		d.sts = d.sts | ev;
		d.irq = |(d.sts & d.ien);
		// Clock controls from registered fields
		d.in_stop = (d.pm == CPR_PM_STOP);
		d.in_sleep = (d.pm == CPR_PM_SLEEP);
		d.osc_run = ~d.in_sleep & (~d.in_stop | d.clock_source_control[`CPR_SRC_OSC_KEEP]);
		d.main_on = ~d.clock_source_control[`CPR_SRC_MAIN_OFF];
		d.sec_on = ~d.clock_source_control[`CPR_SRC_SEC_OFF];
		d.root_sel = d.clock_source_control[`CPR_SRC_ROOT_SEL];
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	// Synchronous reset to documented values
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
			q.clock_source_control <= `CPR_RST_CLOCK_SOURCE_CONTROL;
			q.clkdiv <= `CPR_RST_CLKDIV;
			q.pwr <= `CPR_RST_PWR;
			q.srst <= `CPR_RST_SRST;
			q.pm <= CPR_PM_RUN;
			q.osc_run <= 1'b1;
			q.main_on <= 1'b1;
			q.sec_on <= 1'b1;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs, all from flops

	assign wb_dat_o = q.rdat;
	assign wb_ack_o = q.ack;
	assign osc_run_o = q.osc_run;
	assign main_pll_on_o = q.main_on;
	assign secondary_pll_on_o = q.sec_on;
	assign root_source_select_o = q.root_sel;
	assign sys_bus_clk_en_o = sys_tick;
	assign camera_clock_divider_o = q.clkdiv[`CPR_DIV_CAMERA +: 4];
	assign video_clock_divider_o = q.clkdiv[`CPR_DIV_VIDEO +: 4];
	assign stop_mode_o = q.in_stop;
	assign sleep_mode_o = q.in_sleep;
	assign soft_reset_o = q.srst_out;
	assign fast_interrupt_o = q.fast_interrupt;
	assign irq_o = q.irq;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Oscillator follows the keep bit while stopped
	property p_osc_stop;
		stop_mode_o |-> (osc_run_o == q.clock_source_control[`CPR_SRC_OSC_KEEP]);
	endproperty
	a_osc_stop: assert property (p_osc_stop) else $error("osc state wrong in stop");

	// PLL enables mirror their off bits
	property p_pll_on;
		##1 (main_pll_on_o == ~$past(d.clock_source_control[`CPR_SRC_MAIN_OFF]))
			&& (secondary_pll_on_o == ~$past(d.clock_source_control[`CPR_SRC_SEC_OFF]));
	endproperty
	a_pll_on: assert property (p_pll_on) else $error("pll enable mismatch");

	// Root select follows its bit
	property p_root_sel;
		root_source_select_o == q.clock_source_control[`CPR_SRC_ROOT_SEL];
	endproperty
	a_root_sel: assert property (p_root_sel) else $error("root select mismatch");

	// Ratio 1:4 held over a whole period gives one tick in four cycles;
	// a ratio change mid-period may legally shorten that period
	property p_sys_ratio;
		($past(sys_tick, 4) && $past(q.clkdiv[`CPR_DIV_SYS +: 2], 1) == 2'h3
			&& $past(q.clkdiv[`CPR_DIV_SYS +: 2], 2) == 2'h3
			&& $past(q.clkdiv[`CPR_DIV_SYS +: 2], 3) == 2'h3
			&& $past(q.clkdiv[`CPR_DIV_SYS +: 2], 4) == 2'h3)
			|-> sys_tick && !$past(sys_tick, 1) && !$past(sys_tick, 2) && !$past(sys_tick, 3);
	endproperty
	a_sys_ratio: assert property (p_sys_ratio) else $error("system ratio wrong");

	// No stop or sleep while waiting without standby or a battery fault edge
	property p_hs_wait;
		(q.pm == CPR_PM_WAIT && !q.s2[`CPR_SYN_STBY] && !bf_rise) |=> (q.pm == CPR_PM_WAIT);
	endproperty
	a_hs_wait: assert property (p_hs_wait) else $error("entered without standby");

	// Masked modem event alone keeps sleep
	property p_modem_mask;
		(sleep_mode_o && q.pwr[`CPR_PWR_MODEM_MASK] && !q.s2[`CPR_SYN_WAKE]) |=> sleep_mode_o;
	endproperty
	a_modem_mask: assert property (p_modem_mask) else $error("masked modem woke");

	// Sleep code without handshake sleeps within two cycles
	property p_sleep_code;
		(pwr_magic_wr && q.pm == CPR_PM_RUN && !q.pwr[`CPR_PWR_HS_EN]) |-> ##[1:2] sleep_mode_o;
	endproperty
	a_sleep_code: assert property (p_sleep_code) else $error("sleep code ignored");

	// Reset command pulses the reset output next cycle
	property p_soft_reset;
		srst_magic_wr |=> soft_reset_o [*2];
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset missing");

	// Stop request is never cleared by hardware
	property p_stop_hold;
		(q.stop_req && !(wr && wb_req_i.adr == `CPR_ADR_STOP)) |=> q.stop_req;
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("stop bit cleared");

	// Non-magic write never starts a pulse
	property p_no_magic;
		(wr && wb_req_i.adr == `CPR_ADR_SRST && !magic && !soft_reset_o) |=> !soft_reset_o;
	endproperty
	a_no_magic: assert property (p_no_magic) else $error("reset without code");

endmodule

// file: cpr_core_model.sv
// Behavioural processor core: raises standby some cycles after it runs
// the wait instruction. Assumes bench pulses wfi_i after the mode request.
`timescale 1ns/1ns

module cpr_core_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Commands from the bench
	input wire logic wfi_i,
	input wire logic wake_i,
	input wire logic [3:0] dly_i,
	// Standby level to the controller
	output logic standby_o
);
	logic arm_q; // Wait instruction pending
	logic [3:0] cnt_q; // Cycles left before standby

	////////////////////////////////////////////////////////////////
	// Standby only after the wait instruction, dropped on wakeup
	always_ff @(posedge clk_i) begin
		if (rst_i || wake_i) begin
			arm_q <= 1'b0;
			cnt_q <= 4'h0;
			standby_o <= 1'b0; // Wakeup pin or reset ends the wait
		end else if (wfi_i) begin
			arm_q <= 1'b1; // Bench issues this after the request
			cnt_q <= dly_i;
		end else if (arm_q && cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
		end else if (arm_q) begin
			standby_o <= 1'b1;
		end
	end
endmodule

// file: tb_cpr_top.sv
// Self-checking bench for the clock/power/reset controller.
// Assumes cpr_pkg, cpr_top and cpr_core_model are compiled first.
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
	$display("Error at %0t: got %h exp %h", $time, a, e); end end

module tb_cpr_top;
	import cpr_pkg::*;
	logic clk_i, rst_i, wait_for_interrupt_instr, wake, modem, bfault, ext_clk, stby;
	cpr_wb_req_t req;
	logic [31:0] dat, rdat;
	logic ack, osc, mpll, spll, root, ext_en, sys_en, per_en, stp, slp, srst, fast_interrupt, irq;
	logic [3:0] cam, vid;
	int failures, n_checks;

	cpr_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(dat),
		.wb_ack_o(ack), .core_standby_signal_i(stby), .wakeup_i(wake),
		.modem_wakeup_i(modem), .battery_fault_i(bfault), .ext_clk_i(ext_clk),
		.osc_run_o(osc), .main_pll_on_o(mpll), .secondary_pll_on_o(spll),
		.root_source_select_o(root), .ext_clk_en_o(ext_en), .sys_bus_clk_en_o(sys_en),
		.periph_bus_clk_en_o(per_en), .camera_clock_divider_o(cam),
		.video_clock_divider_o(vid), .stop_mode_o(stp), .sleep_mode_o(slp),
		.soft_reset_o(srst), .fast_interrupt_o(fast_interrupt), .irq_o(irq));
	cpr_core_model core (.clk_i(clk_i), .rst_i(rst_i), .wfi_i(wait_for_interrupt_instr), .wake_i(wake),
		.dly_i(4'h9), .standby_o(stby));

	////////////////////////////////////////////////////////////////
	// Clock, free-running external clock, watchdog
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	initial begin
		ext_clk = 1'b0;
		forever begin
			repeat (4) @(posedge clk_i);
			ext_clk <= ~ext_clk;
		end
	end
	initial begin
		repeat (30000) @(posedge clk_i);
		failures++; // Hang counts as a mismatch
		stop_test();
	end

	////////////////////////////////////////////////////////////////
	// Bus and helper tasks; each enters just after an edge
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input bit we = 1);
		req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
		// Only the watchdog ends a lost answer
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		rdat = dat; // Taken at the ack edge only
		req <= '0;
		@(posedge clk_i);
	endtask
	task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
		wr(a, 32'h0, 0);
		`CHK(rdat, e)
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wake_up();
		wake <= 1'b1;
		repeat (20) if ((stp | slp) !== 1'b0) @(posedge clk_i);
		`CHK({stp, slp}, 2'h0)
		wake <= 1'b0;
		wt(4);
	endtask
	task automatic per(input bit s, output int p);
		repeat (20) if ((s ? per_en : sys_en) !== 1'b1) @(posedge clk_i);
		@(posedge clk_i);
		p = 1;
		while ((s ? per_en : sys_en) !== 1'b1 && p < 20) begin
			@(posedge clk_i);
			p++;
		end
	endtask

	////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_regs();
		rd_chk(32'h4000_0024, 32'h4);
		rd_chk(32'h4000_0028, 32'h300);
		rd_chk(32'h4000_0030, 32'h1000);
		wr(32'h4000_0024, 32'hffff_ffff);
		rd_chk(32'h4000_0024, 32'h1b7);
		`CHK({mpll, spll, root}, 3'h1)
		wr(32'h4000_0024, 32'h0);
		wt(2);
		`CHK({mpll, spll, root}, 3'h6)
		wr(32'h4000_0028, 32'hffff_ffff);
		rd_chk(32'h4000_0028, 32'hff7);
		`CHK({cam, vid}, 8'hff)
		wr(32'h4000_0030, 32'hffff_ff00);
		rd_chk(32'h4000_0030, 32'h1e00);
		wr(32'h4000_0050, 32'hffff_ffff); // Unmapped place
		rd_chk(32'h4000_0050, 32'h0);
	endtask
	task automatic t_ratio();
		int p;
		for (int c = 0; c < 8; c++) begin
			wr(32'h4000_0028, 32'(c));
			per(c[0], p);
			per(c[0], p); // Second period, divider resettled
			`CHK(p, (c[2:1] + 1) * (c[0] + 1))
		end
	endtask
	task automatic t_ext();
		int n;
		int codes[4] = '{0, 1, 2, 7};
		int exp[4] = '{20, 10, 5, 20}; // 20 external edges per window
		for (int i = 0; i < 4; i++) begin
			wr(32'h4000_0024, 32'(codes[i]));
			wt(20);
			n = 0;
			repeat (160) begin
				@(posedge clk_i);
				n += ext_en;
			end
			`CHK(n >= exp[i] - 1 && n <= exp[i] + 1, 1'b1)
		end
	endtask
	task automatic t_sleep();
		wr(32'h4000_0030, 32'h0000_00a2); // Handshake off, not the code
		wt(6);
		`CHK(slp, 1'b0)
		wr(32'h4000_0048, 32'h1);
		wr(32'h4000_0030, 32'hffff_e0a3);
		repeat (10) if (slp !== 1'b1) @(posedge clk_i);
		`CHK({slp, osc, irq}, 3'h5)
		wr(32'h4000_0048, 32'h0); // Masked
		wt(2);
		`CHK(irq, 1'b0)
		wr(32'h4000_0048, 32'h1);
		wt(2);
		`CHK(irq, 1'b1)
		wr(32'h4000_0044, 32'h1); // Clear
		wt(2);
		`CHK(irq, 1'b0)
		wake_up();
	endtask
	task automatic t_stop();
		wr(32'h4000_0024, 32'h100); // Oscillator kept
		wr(32'h4000_0030, 32'h1000); // Handshake on
		wr(32'h4000_0020, 32'h1);
		wt(10);
		`CHK(stp, 1'b0)
		wait_for_interrupt_instr <= 1'b1;
		@(posedge clk_i);
		wait_for_interrupt_instr <= 1'b0;
		repeat (30) if (stp !== 1'b1) @(posedge clk_i);
		`CHK({stp, osc}, 2'h3)
		wake_up();
		rd_chk(32'h4000_0020, 32'h1);
		wr(32'h4000_0020, 32'h0);
		wr(32'h4000_0024, 32'h0);
		wr(32'h4000_0030, 32'h0);
		wr(32'h4000_0020, 32'h1);
		repeat (10) if (stp !== 1'b1) @(posedge clk_i);
		`CHK({stp, osc}, 2'h2)
		wake_up();
		wr(32'h4000_0020, 32'h0);
	endtask
	task automatic t_modem();
		wr(32'h4000_0030, 32'h0000_08a3); // Masked modem
		wt(6);
		modem <= 1'b1;
		wt(8);
		`CHK(slp, 1'b1)
		modem <= 1'b0;
		wt(4); // Let the synced modem level fall before unmasking
		wr(32'h4000_0030, 32'h0);
		modem <= 1'b1;
		repeat (20) if (slp !== 1'b0) @(posedge clk_i);
		`CHK(slp, 1'b0)
		modem <= 1'b0;
		wt(4);
	endtask
	task automatic t_fault();
		wr(32'h4000_0044, 32'h7); // Drop events of earlier scenarios
		wr(32'h4000_0030, 32'h200); // Fast interrupt policy
		bfault <= 1'b1;
		wt(6);
		`CHK({fast_interrupt, slp}, 2'h2)
		rd_chk(32'h4000_0040, 32'h4);
		bfault <= 1'b0;
		wr(32'h4000_0044, 32'h7);
		wr(32'h4000_0030, 32'h400); // Ignore policy
		bfault <= 1'b1;
		wt(6);
		`CHK({fast_interrupt, slp}, 2'h0)
		bfault <= 1'b0;
		wr(32'h4000_0030, 32'h0); // Emergency sleep policy
		bfault <= 1'b1;
		repeat (20) if (slp !== 1'b1) @(posedge clk_i);
		`CHK({fast_interrupt, slp}, 2'h1)
		bfault <= 1'b0;
		wake_up();
	endtask
	task automatic t_srst();
		int n;
		wr(32'h4000_0038, 32'h0000_0012);
		wt(5);
		`CHK(srst, 1'b0)
		wr(32'h4000_0038, 32'hffff_ffa3);
		repeat (5) if (srst !== 1'b1) @(posedge clk_i);
		n = 0;
		while (srst === 1'b1 && n < 40) begin
			@(posedge clk_i);
			n++;
		end
		// First high cycle already passed inside the bus task
		`CHK(n + 1, 16)
	endtask

	////////////////////////////////////////////////////////////////
	// Verdict, the single end of the run
	task automatic stop_test();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		failures = 0;
		n_checks = 0;
		req = '0;
		rst_i = 1'b1;
		{wait_for_interrupt_instr, wake, modem, bfault} = 4'h0;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_regs();
		t_ratio();
		t_ext();
		t_sleep();
		t_stop();
		t_modem();
		t_fault();
		t_srst();
		stop_test();
	end
endmodule
